// [vfg_pkg.sv]
// Purpose: Constants for the wide-vector feature gating block
// Assumes: Bit positions of the extended feature word and enable word
// Notes: Opcode class codes are local to this block
package vfg_pkg;
    // Feature word bit positions, leaf 07H subleaf 0
    localparam int unsigned FW_FOUNDATION = 16;
    localparam int unsigned FW_DWORD_QWORD = 17;
    localparam int unsigned FW_PREFETCH = 26;
    localparam int unsigned FW_EXP_RECIP = 27;
    localparam int unsigned FW_CONFLICT = 28;
    localparam int unsigned FW_BYTE_WORD = 30;
    localparam int unsigned FW_SHORT_LEN = 31;
    // Leaf 1 word, state-save flag position
    localparam int unsigned L1_OS_SAVE = 27;
    // Query leaf codes
    localparam logic [31:0] LEAF_BASIC = 32'h0000_0001;
    localparam logic [31:0] LEAF_EXT = 32'h0000_0007;
    localparam logic [31:0] SUBLEAF_ZERO = 32'h0000_0000;
    // Implemented feature word, fixed by implementation
    localparam logic [31:0] FEAT_WORD = 32'hdc03_0000;
    // Enable word bits the groups need: 7:5 and 2:1
    localparam logic [63:0] EW_NEEDED = 64'h0000_0000_0000_00e6;
    // Vector-length field encodings
    localparam logic [1:0] VL_128 = 2'h0;
    localparam logic [1:0] VL_256 = 2'h1;
    localparam logic [1:0] VL_512 = 2'h2;
    // Instruction classes seen by the gate
    typedef enum logic [3:0] {
        VFG_OP_FOUND, VFG_OP_FOUND_L256, VFG_OP_DQ, VFG_OP_DQ_L256, VFG_OP_CD,
        VFG_OP_BW, VFG_OP_ER, VFG_OP_PF, VFG_OP_WPF, VFG_OP_STATE_SAVE, VFG_OP_STATE_RESTORE,
        VFG_OP_CTRL_READ, VFG_OP_CTRL_WRITE, VFG_OP_OTHER
    } vfg_op_e;
endpackage

// [vfg_len_check.sv]
// Purpose: Vector-length legality for one instruction class
// Assumes: Feature word is constant
// Notes: Pure combinational leaf
`timescale 1ns/1ps
`default_nettype none
module vfg_len_check
    import vfg_pkg::*;
(
    // Decoded instruction
    input wire vfg_op_e op_i,
    input wire logic [1:0] vl_i,
    input wire logic [31:0] feat_i,
    // Verdict
    output logic len_ok_o
);
    // Own group flag of the class
    logic grp_ok;
    logic lane_only;
    assign grp_ok = (op_i == VFG_OP_DQ || op_i == VFG_OP_DQ_L256) ? feat_i[FW_DWORD_QWORD] :
                    (op_i == VFG_OP_CD) ? feat_i[FW_CONFLICT] :
                    (op_i == VFG_OP_BW) ? feat_i[FW_BYTE_WORD] : 1'b1;
    assign lane_only = (op_i == VFG_OP_FOUND_L256) || (op_i == VFG_OP_DQ_L256);
    // Length select: 512 always, shorter under short-length flag
    assign len_ok_o = (vl_i == VL_512) ? 1'b1 :
                      !(feat_i[FW_SHORT_LEN] && feat_i[FW_FOUNDATION] && grp_ok) ? 1'b0 :
                      (vl_i == VL_256) ? 1'b1 :
                      (vl_i == VL_128) ? !lane_only : 1'b0;
endmodule
`default_nettype wire

// [vfg_gate.sv]
// Purpose: Feature query answers and instruction legality for wide-vector groups
// Assumes: Decoder presents one classified instruction per valid cycle
// Notes: Verdict appears one cycle after the request
//
// Behaviour
// - Feature word bit 27 reports exponential and reciprocal group present.
// - Feature word bit 26 reports gather/scatter prefetch group present.
// - State-save flag set implies save, restore, control read and enable word exist.
// - Extended-control write allowed only at privileged level.
// - Write-intent prefetch hint needs no OS vector state enabling.
// - Foundation 16, conflict 28, dword/qword 17, byte/word 30 flags.
// - Groups other than exponential and prefetch choose 512, 256 or 128 bits via the length field.
// - Bit 31 flag enables encodings shorter than 512 bits.
// - Lane-crossing foundation and dword/qword ops allow 256 but not 128.
`timescale 1ns/1ps
`default_nettype none
module vfg_gate
    import vfg_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Feature query
    input wire logic query_valid_i,
    input wire logic [31:0] query_leaf_i,
    input wire logic [31:0] query_subleaf_i,
    output logic query_valid_o,
    output logic [31:0] query_word_o,
    // Operating state
    input wire logic os_state_save_flag_i,
    input wire logic privileged_i,
    input wire logic [63:0] ext_state_enable_word_i,
    // Instruction check
    input wire logic instr_valid_i,
    input wire vfg_op_e instr_op_i,
    input wire logic [1:0] vector_length_field_i,
    output logic verdict_valid_o,
    output logic instr_legal_o,
    output logic instr_fault_o
);
    // ----------------------------------------
    // Feature query decode
    // ----------------------------------------
    logic ask_leaf7;
    logic ask_leaf1;
    logic [31:0] leaf7_word;
    logic [31:0] leaf1_word;
    logic [31:0] query_word_nxt;
    // Leaf 7 holds the group flags, leaf 1 the save flag
    // Leaf select; subleaf only qualifies leaf 7
    // Full-width compares keep wrapped leaf numbers out
    assign ask_leaf7 = (query_leaf_i == LEAF_EXT) && (query_subleaf_i == SUBLEAF_ZERO);
    assign ask_leaf1 = (query_leaf_i == LEAF_BASIC);
    // Constant word, so repeated queries always agree
    assign leaf7_word = FEAT_WORD;
    // Leaf 1 word carries only the state-save flag
    // Other leaf 1 bits belong to the host core
    assign leaf1_word = 32'(os_state_save_flag_i) << L1_OS_SAVE;
    // Unknown leaves and other subleaves answer zero
    assign query_word_nxt = ask_leaf7 ? leaf7_word :
                            ask_leaf1 ? leaf1_word : 32'h0;

    // ----------------------------------------
    // Reported group flags
    // ----------------------------------------
    logic flag_foundation;
    logic flag_dword_qword;
    logic flag_prefetch;
    logic flag_exp_recip;
    logic flag_conflict;
    logic flag_byte_word;
    // Each group answers with its own bit of the constant word
    // Named once so query and legality read the same bit
    assign flag_foundation = leaf7_word[FW_FOUNDATION];
    assign flag_dword_qword = leaf7_word[FW_DWORD_QWORD];
    assign flag_prefetch = leaf7_word[FW_PREFETCH];
    assign flag_exp_recip = leaf7_word[FW_EXP_RECIP];
    assign flag_conflict = leaf7_word[FW_CONFLICT];
    assign flag_byte_word = leaf7_word[FW_BYTE_WORD];

    // ----------------------------------------
    // Class decode
    // ----------------------------------------
    logic cls_write_hint;
    logic cls_state_mgmt;
    logic cls_ctrl_write;
    logic cls_fixed_512;
    logic cls_other;
    logic cls_dword_qword;
    // Write hint is legal whatever state the OS has enabled
    assign cls_write_hint = (instr_op_i == VFG_OP_WPF);
    // Save, restore and control read follow the save flag
    assign cls_state_mgmt = (instr_op_i == VFG_OP_STATE_SAVE) || (instr_op_i == VFG_OP_STATE_RESTORE) ||
                            (instr_op_i == VFG_OP_CTRL_READ);
    // Control write also needs the privileged level
    assign cls_ctrl_write = (instr_op_i == VFG_OP_CTRL_WRITE);
    // Exponential and prefetch groups run at full length only
    assign cls_fixed_512 = (instr_op_i == VFG_OP_ER) || (instr_op_i == VFG_OP_PF);
    // Non-vector classes pass untouched
    assign cls_other = (instr_op_i == VFG_OP_OTHER);
    // Both dword/qword classes share one group flag
    assign cls_dword_qword = (instr_op_i == VFG_OP_DQ) || (instr_op_i == VFG_OP_DQ_L256);

    // ----------------------------------------
    // Operating state
    // ----------------------------------------
    logic ew_vector_ok;
    logic state_ok;
    logic ctrl_write_ok;
    // Mask, upper vector and base vector state all enabled
    assign ew_vector_ok = (ext_state_enable_word_i & EW_NEEDED) == EW_NEEDED;
    // The save flag alone is not enough for vector groups,
    // since the OS may leave some state disabled
    assign state_ok = os_state_save_flag_i && ew_vector_ok;
    // Application code never reaches the control write
    assign ctrl_write_ok = os_state_save_flag_i && privileged_i;

    // ----------------------------------------
    // Instruction legality
    // ----------------------------------------
    logic len_ok;
    logic group_present;
    logic is_512;
    logic fixed_legal;
    logic group_legal;
    logic legal_nxt;
    // Length check sees the constant word, not a live input,
    // so no input can widen what is accepted
    vfg_len_check u_len (
        .op_i(instr_op_i),
        .vl_i(vector_length_field_i),
        .feat_i(leaf7_word),
        .len_ok_o(len_ok)
    );
    // Group flag presence per class
    assign group_present = (instr_op_i == VFG_OP_ER) ? flag_exp_recip :
                           (instr_op_i == VFG_OP_PF) ? flag_prefetch :
                           (instr_op_i == VFG_OP_CD) ? flag_conflict :
                           (instr_op_i == VFG_OP_BW) ? flag_byte_word :
                           cls_dword_qword ? flag_dword_qword : flag_foundation;
    // Full-length encoding selected
    assign is_512 = (vector_length_field_i == VL_512);
    // Full-length groups refuse every shorter encoding
    assign fixed_legal = state_ok && group_present && is_512;
    // Sibling groups pick their length through the length check
    assign group_legal = state_ok && group_present && len_ok;
    // Final verdict by class; anything unnamed is a sibling group
    assign legal_nxt = cls_write_hint ? 1'b1 :
                       cls_state_mgmt ? os_state_save_flag_i :
                       cls_ctrl_write ? ctrl_write_ok :
                       cls_fixed_512 ? fixed_legal :
                       cls_other ? 1'b1 : group_legal;

    // ----------------------------------------
    // Next output values
    // ----------------------------------------
    logic [31:0] answer_word_nxt;
    logic legal_out_nxt;
    logic fault_out_nxt;
    // Word is zero between answers, so no stale word lingers
    assign answer_word_nxt = query_valid_i ? query_word_nxt : 32'h0;
    // Legal and fault are exclusive; a consumer may watch either
    assign legal_out_nxt = instr_valid_i && legal_nxt;
    assign fault_out_nxt = instr_valid_i && !legal_nxt;

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    // Every output is a flop, so the core sees no glitches
    // Answer pulse, one cycle after the query
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            query_valid_o <= 1'b0;
        end else begin
            query_valid_o <= query_valid_i;
        end
    end

    // Answer word
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            query_word_o <= 32'h0;
        end else begin
            query_word_o <= answer_word_nxt;
        end
    end

    // Verdict pulse, one cycle after the instruction
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            verdict_valid_o <= 1'b0;
        end else begin
            verdict_valid_o <= instr_valid_i;
        end
    end

    // Legal flag
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            instr_legal_o <= 1'b0;
        end else begin
            instr_legal_o <= legal_out_nxt;
        end
    end

    // Fault flag
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            instr_fault_o <= 1'b0;
        end else begin
            instr_fault_o <= fault_out_nxt;
        end
    end
endmodule
`default_nettype wire

// [vfg_gate_properties.sv]
// Purpose: Port properties of the gate
// Assumes: One clock, sync reset
// Notes: Bound after the module
`timescale 1ns/1ps
`default_nettype none
module vfg_props
    import vfg_pkg::*;
(
    // Gate ports, inputs and outputs alike
    input wire logic clock_i, rst_n_i, query_valid_i, os_state_save_flag_i, privileged_i, instr_valid_i,
    input wire logic [31:0] query_leaf_i, query_subleaf_i, query_word_o,
    input wire logic [63:0] ext_state_enable_word_i,
    input wire vfg_op_e instr_op_i,
    input wire logic [1:0] vector_length_field_i,
    input wire logic query_valid_o, verdict_valid_o, instr_legal_o, instr_fault_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // Request decodes
    wire logic ask7 = query_valid_i && query_leaf_i == LEAF_EXT && query_subleaf_i == SUBLEAF_ZERO;
    wire logic ask1 = query_valid_i && query_leaf_i == LEAF_BASIC;
    wire logic st_ok = os_state_save_flag_i && (ext_state_enable_word_i & EW_NEEDED) == EW_NEEDED;
    wire logic iv = instr_valid_i;
    // Answers tied to their requests
    property p_flags; ask7 |=> query_valid_o && query_word_o[FW_EXP_RECIP] && query_word_o[FW_PREFETCH]; endproperty
    a_flags: assert property (p_flags) else $error("group flags low");
    property p_word; ask7 |=> query_word_o == FEAT_WORD; endproperty
    a_word: assert property (p_word) else $error("feature word wrong");
    property p_leaf1; ask1 |=> query_word_o[L1_OS_SAVE] == $past(os_state_save_flag_i); endproperty
    a_leaf1: assert property (p_leaf1) else $error("save flag wrong");
    property p_save;
        iv && instr_op_i inside {VFG_OP_STATE_SAVE, VFG_OP_STATE_RESTORE, VFG_OP_CTRL_READ}
        |=> verdict_valid_o && instr_legal_o == $past(os_state_save_flag_i);
    endproperty
    a_save: assert property (p_save) else $error("save verdict wrong");
    property p_xset; iv && instr_op_i == VFG_OP_CTRL_WRITE && !privileged_i |=> verdict_valid_o && instr_fault_o; endproperty
    a_xset: assert property (p_xset) else $error("control write allowed");
    property p_wpf; iv && instr_op_i == VFG_OP_WPF |=> verdict_valid_o && instr_legal_o; endproperty
    a_wpf: assert property (p_wpf) else $error("hint refused");
    property p_short;
        iv && instr_op_i inside {VFG_OP_FOUND_L256, VFG_OP_DQ_L256} && vector_length_field_i == VL_128
        |=> instr_fault_o;
    endproperty
    a_short: assert property (p_short) else $error("short encoding taken");
    property p_len;
        iv && instr_op_i == VFG_OP_CD && st_ok && vector_length_field_i != 2'h3 |=> instr_legal_o;
    endproperty
    a_len: assert property (p_len) else $error("length refused");
    property p_fixed;
        iv && instr_op_i inside {VFG_OP_ER, VFG_OP_PF} && vector_length_field_i != VL_512 |=> instr_fault_o;
    endproperty
    a_fixed: assert property (p_fixed) else $error("short fixed-length encoding taken");
    property p_idle; !query_valid_o |-> query_word_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("stale query word");
    property p_one; verdict_valid_o |-> $past(iv) && instr_legal_o != instr_fault_o; endproperty
    a_one: assert property (p_one) else $error("verdict malformed");
endmodule
bind vfg_gate vfg_props u_props (.clock_i, .rst_n_i, .query_valid_i, .os_state_save_flag_i, .privileged_i,
    .instr_valid_i, .query_leaf_i, .query_subleaf_i, .query_word_o, .ext_state_enable_word_i, .instr_op_i,
    .vector_length_field_i, .query_valid_o, .verdict_valid_o, .instr_legal_o, .instr_fault_o);
`default_nettype wire

// [vector_feature_gating_tb.sv]
// Purpose: Random self-checking bench for the gate
// Assumes: Answers one cycle after each request
// Notes: Driver queues notes, monitor pops them
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module vector_feature_gating_tb;
    import vfg_pkg::*;
    logic clock_i = 0, rst_n_i = 0, query_valid_i = 0, os_state_save_flag_i = 0, privileged_i = 0, instr_valid_i = 0;
    logic [31:0] query_leaf_i = 0, query_subleaf_i = 0, query_word_o, w;
    logic [63:0] ext_state_enable_word_i = 0;
    logic [1:0] vector_length_field_i = 0, v;
    vfg_op_e instr_op_i = VFG_OP_OTHER;
    logic query_valid_o, verdict_valid_o, instr_legal_o, instr_fault_o;
    logic [31:0] qq[$];
    logic [1:0] iq[$];
    int miscompares = 0, comparisons = 0, cyc = 0;
    vfg_gate dut_u (.clock_i, .rst_n_i, .query_valid_i, .query_leaf_i, .query_subleaf_i, .query_valid_o, .query_word_o,
        .os_state_save_flag_i, .privileged_i, .ext_state_enable_word_i, .instr_valid_i, .instr_op_i,
        .vector_length_field_i, .verdict_valid_o, .instr_legal_o, .instr_fault_o);
    // Expected legality of one instruction
    function automatic logic ok(vfg_op_e o, logic [1:0] l, logic s, logic f, logic p);
        case (o)
            VFG_OP_WPF, VFG_OP_OTHER: ok = 1'b1;
            VFG_OP_STATE_SAVE, VFG_OP_STATE_RESTORE, VFG_OP_CTRL_READ: ok = f;
            VFG_OP_CTRL_WRITE: ok = f && p;
            VFG_OP_ER, VFG_OP_PF: ok = s && l == VL_512;
            VFG_OP_FOUND_L256, VFG_OP_DQ_L256: ok = s && (l == VL_256 || l == VL_512);
            default: ok = s && l != 2'h3;
        endcase
    endfunction
    // Verdict and closing report
    task automatic complete_run();
        `CHK("pending", 0, qq.size() + iq.size())
        if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Clock and hang limit
    initial forever #12.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 2000) begin
            miscompares++;
            complete_run();
        end
    end
    // Monitor pops the oldest note
    always @(negedge clock_i) begin
        if (query_valid_o === 1'b1) begin
            w = qq.pop_front();
            `CHK("query_word", w, query_word_o)
        end
        if (verdict_valid_o === 1'b1) begin
            v = iq.pop_front();
            `CHK("verdict", v, {instr_legal_o, instr_fault_o})
        end
    end
    // Driver, back to back random requests
    initial begin
        logic a, b, f, p, s;
        logic [1:0] l;
        logic [31:0] lf, sb, fw;
        logic [63:0] e;
        vfg_op_e o;
        void'($urandom(27));
        // Expected group flags, built bit by bit from their positions
        fw = (32'h1 << FW_FOUNDATION) | (32'h1 << FW_DWORD_QWORD) | (32'h1 << FW_PREFETCH) |
             (32'h1 << FW_EXP_RECIP) | (32'h1 << FW_CONFLICT) | (32'h1 << FW_BYTE_WORD) | (32'h1 << FW_SHORT_LEN);
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (600) begin
            @(posedge clock_i);
            {a, b, p} = $urandom;
            f = $urandom_range(0, 3) != 0;
            lf = $urandom_range(0, 2) == 0 ? LEAF_BASIC : ($urandom_range(0, 3) == 0 ? $urandom : LEAF_EXT);
            sb = $urandom_range(0, 3) == 0 ? $urandom_range(0, 1) : SUBLEAF_ZERO;
            e = {$urandom, $urandom} | ($urandom_range(0, 3) != 0 ? EW_NEEDED : 64'h0);
            s = f && (e[7:5] == 3'h7) && (e[2:1] == 2'h3);
            l = $urandom;
            o = vfg_op_e'($urandom_range(0, 13));
            if (a) qq.push_back(lf == LEAF_EXT && sb == SUBLEAF_ZERO ? fw :
                                (lf == LEAF_BASIC ? {4'h0, f, 27'h0} : 32'h0));
            if (b) iq.push_back({ok(o, l, s, f, p), ~ok(o, l, s, f, p)});
            {query_valid_i, query_leaf_i, query_subleaf_i, os_state_save_flag_i, privileged_i} <= {a, lf, sb, f, p};
            {instr_valid_i, vector_length_field_i, ext_state_enable_word_i} <= {b, l, e};
            instr_op_i <= o;
        end
        @(posedge clock_i);
        {query_valid_i, instr_valid_i} <= 2'h0;
        repeat (3) @(posedge clock_i);
        complete_run();
    end
endmodule
`default_nettype wire
